// >>> hfp_pkg.sv
// Package for the host FIFO port and register map decoder
// Assumes a 16-bit host bus addressing 16-bit halves of 32-bit words
package hfp_pkg;
	// ------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------
	localparam logic [7:0] RXD_LO       = 8'h00;
	localparam logic [7:0] RXD_HI       = 8'h3c;
	localparam logic [7:0] RXS_POP      = 8'h40;
	localparam logic [7:0] RXS_NONDESTRUCTIVE_READ_PORT     = 8'h44;
	localparam logic [7:0] TXS_POP      = 8'h48;
	localparam logic [7:0] TXS_NONDESTRUCTIVE_READ_PORT     = 8'h4c;
	localparam logic [7:0] OFF_ID       = 8'h50;
	localparam logic [7:0] OFF_IRQCFG   = 8'h54;
	localparam logic [7:0] OFF_INTFLG   = 8'h58;
	localparam logic [7:0] OFF_INTMSK   = 8'h5c;
	localparam logic [7:0] OFF_RSV60    = 8'h60;
	localparam logic [7:0] OFF_ENDIAN   = 8'h64;
	localparam logic [7:0] OFF_FIFOIRQ  = 8'h68;
	localparam logic [7:0] OFF_RXCFG    = 8'h6c;
	localparam logic [7:0] OFF_TXCFG    = 8'h70;
	localparam logic [7:0] OFF_HWCFG    = 8'h74;
	localparam logic [7:0] OFF_RXPATH   = 8'h78;
	localparam logic [7:0] OFF_RXLVL    = 8'h7c;
	localparam logic [7:0] OFF_TXLVL    = 8'h80;
	localparam logic [7:0] OFF_PWR      = 8'h84;
	localparam logic [7:0] OFF_IOCFG    = 8'h88;
	localparam logic [7:0] OFF_TMRCFG   = 8'h8c;
	localparam logic [7:0] OFF_TMRCNT   = 8'h90;
	localparam logic [7:0] OFF_RSV94    = 8'h94;
	localparam logic [7:0] OFF_HWORD    = 8'h98;
	localparam logic [7:0] OFF_CYCLE    = 8'h9c;
	localparam logic [7:0] OFF_DROP     = 8'ha0;
	localparam logic [7:0] OFF_MACCMD   = 8'ha4;
	localparam logic [7:0] OFF_MACDAT   = 8'ha8;
	localparam logic [7:0] OFF_FLOW     = 8'hac;
	localparam logic [7:0] OFF_ROMCMD   = 8'hb0;
	localparam logic [7:0] OFF_ROMDAT   = 8'hb4;
	localparam logic [7:0] OFF_RSV_LO   = 8'hb8;
	// ------------------------------------------------------------
	// Identity and constants
	// ------------------------------------------------------------
	// Arbitrary neutral values
	localparam logic [15:0] CHIP_ID_VAL = 16'h0a5c;
	localparam logic [15:0] CHIP_REV_VAL = 16'h0001;
	localparam logic [31:0] ENDIAN_VAL  = 32'h87654321;
	localparam logic [31:0] RSV_VAL     = 32'h00000000;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RST_ZERO    = 32'h00000000;
	localparam logic [31:0] RST_FIFOIRQ = 32'h48000000;
	localparam logic [31:0] RST_HWCFG   = 32'h00050000;
	localparam logic [31:0] RST_TMR     = 32'h0000ffff;
	localparam logic [31:0] RST_TXLVL   = 32'h00001200;
	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        cs;
		logic        rd;
		logic        wr;
		logic [7:1]  addr;
		logic [15:0] wdata;
	} hfp_hreq_s;
	typedef struct packed {
		logic        pop;
		logic [31:0] data;
	} hfp_fifo_rd_s;
endpackage

// >>> hfp_reg.sv
// Single 32-bit writable register with loadable value
// Assumes write strobe and data come from the word assembler
`timescale 1ns/1ps
module hfp_reg #(
	parameter logic [31:0] RST = 32'h00000000
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        sw_rst,
	// Write
	input  wire logic        we,
	input  wire logic [31:0] wd,
	// Value
	output logic      [31:0] q
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			q <= RST;
		end else if (sw_rst) begin
			q <= RST;
		end else if (we) begin
			q <= wd;
		end
	end
endmodule

// >>> hfp_top.sv
// Host FIFO ports and register map decoder
// Assumes host drives strobes synchronous to sys_clk, one cycle each,
// low half of a word first, then high half
//
// Overview of operation
// RL1 - Status pop port returns head and removes
// RL2 - Status nondestructive_read_port port returns head, keeps FIFO
// RL3 - Every data port read pops data head
// RL4 - Data read port aliased at sixteen words
// RL5 - Receive FIFOs are read only to host
// RL6 - Transmit status pop returns head and removes
// RL7 - Transmit status nondestructive_read_port returns head only
// RL8 - Transmit data write only, sixteen aliases
// RL9 - Identity register: chip id, revision, read only
// RL10 - Endian probe always returns fixed pattern
// RL11 - Reserved offsets decoded, reads undefined
// RL12 - Timer config and count reset to ffff
// RL13 - MAC indirect command, data reset zero
// RL14 - Dropped frame counter readable, resets zero
// RL15 - IO pin config at 88h resets zero
// RL16 - Flow control config at ACh resets zero
// RL17 - Words move as two 16-bit halves
// RL18 - Writes to read-only locations do nothing
// RL19 - One pop per whole word, on high half
// RL20 - Defaults restored by hardware and software reset
`timescale 1ns/1ps
module hfp_top (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rstn,
	input  wire logic                  sw_rst,
	// Host bus
	input  wire hfp_pkg::hfp_hreq_s    host,
	output logic      [15:0]           host_rdata,
	output logic                       host_rvalid,
	// Receive status FIFO
	input  wire logic [31:0]           rxs_head,
	output logic                       rxs_pop,
	// Receive data FIFO
	input  wire logic [31:0]           rxd_head,
	output logic                       rxd_pop,
	// Transmit status FIFO
	input  wire logic [31:0]           txs_head,
	output logic                       txs_pop,
	// Transmit data FIFO
	output logic      [31:0]           txd_data,
	output logic                       txd_push,
	// Function block status
	input  wire logic [31:0]           rx_levels,
	input  wire logic [31:0]           tx_levels,
	input  wire logic [31:0]           tmr_count,
	input  wire logic [31:0]           cyc_count,
	input  wire logic [31:0]           drop_count,
	input  wire logic [31:0]           mac_rdata,
	input  wire logic                  mac_rvalid,
	// Configuration outputs and drop counter clear
	output logic      [31:0]           io_cfg,
	output logic      [31:0]           tmr_cfg,
	output logic      [31:0]           mac_cmd,
	output logic      [31:0]           mac_wdata,
	output logic      [31:0]           flow_cfg,
	output logic                       drop_clr
);
	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		HFP_A_NONE = 5'b00001,
		HFP_A_RXD  = 5'b00010,
		HFP_A_TXD  = 5'b00100,
		HFP_A_REG  = 5'b01000,
		HFP_A_RSV  = 5'b10000
	} hfp_area_e;

	function automatic hfp_area_e area_of(input logic [7:0] off,
		input logic wr);
		if (off <= hfp_pkg::RXD_HI) begin
			area_of = wr ? HFP_A_TXD : HFP_A_RXD; // RL4 RL8
		end else if (off >= hfp_pkg::RXS_POP && off < hfp_pkg::OFF_ID) begin
			area_of = HFP_A_REG;
		end else if (off == hfp_pkg::OFF_RSV60 ||
			off == hfp_pkg::OFF_RSV94 || off >= hfp_pkg::OFF_RSV_LO) begin
			area_of = HFP_A_RSV;
		end else begin
			area_of = HFP_A_REG;
		end
	endfunction

	logic [7:0]  byte_off;
	logic        hi_half;
	logic        rd_stb;
	logic        wr_stb;
	hfp_area_e   area;
	assign byte_off = {host.addr[7:2], 2'b00};
	assign hi_half  = host.addr[1];
	assign rd_stb   = host.cs && host.rd;
	assign wr_stb   = host.cs && host.wr;
	assign area     = area_of(byte_off, wr_stb);

	// ------------------------------------------------------------
	// Write assembly
	// ------------------------------------------------------------
	logic [15:0] wlo_r;
	logic        wword;
	logic [31:0] wfull;
	assign wword = wr_stb && hi_half;
	assign wfull = {host.wdata, wlo_r};

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wlo_r <= 16'h0000;
		end else if (wr_stb && !hi_half) begin
			wlo_r <= host.wdata; // RL17
		end
	end

	logic we_io;
	logic we_tmr;
	logic we_cmd;
	logic we_dat;
	logic we_flow;
	assign we_io   = wword && byte_off == hfp_pkg::OFF_IOCFG;  // RL15
	assign we_tmr  = wword && byte_off == hfp_pkg::OFF_TMRCFG; // RL12
	assign we_cmd  = wword && byte_off == hfp_pkg::OFF_MACCMD; // RL13
	assign we_dat  = wword && byte_off == hfp_pkg::OFF_MACDAT; // RL13
	assign we_flow = wword && byte_off == hfp_pkg::OFF_FLOW;   // RL16

	logic [31:0] io_q;
	logic [31:0] tmr_q;
	logic [31:0] cmd_q;
	logic [31:0] dat_q;
	logic [31:0] flow_q;

	// ------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------
	hfp_reg #(.RST(hfp_pkg::RST_ZERO)) u_io (
		.sys_clk (sys_clk), .rstn (rstn), .sw_rst (sw_rst),
		.we (we_io), .wd (wfull), .q (io_q)
	); // RL20
	hfp_reg #(.RST(hfp_pkg::RST_TMR)) u_tmr (
		.sys_clk (sys_clk), .rstn (rstn), .sw_rst (sw_rst),
		.we (we_tmr), .wd (wfull), .q (tmr_q)
	); // RL12
	hfp_reg #(.RST(hfp_pkg::RST_ZERO)) u_cmd (
		.sys_clk (sys_clk), .rstn (rstn), .sw_rst (sw_rst),
		.we (we_cmd), .wd (wfull), .q (cmd_q)
	);
	hfp_reg #(.RST(hfp_pkg::RST_ZERO)) u_flow (
		.sys_clk (sys_clk), .rstn (rstn), .sw_rst (sw_rst),
		.we (we_flow), .wd (wfull), .q (flow_q)
	);

	// Data register also loads MAC read results
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dat_q <= hfp_pkg::RST_ZERO;
		end else if (sw_rst) begin
			dat_q <= hfp_pkg::RST_ZERO; // RL20
		end else if (we_dat) begin
			dat_q <= wfull;
		end else if (mac_rvalid) begin
			dat_q <= mac_rdata; // RL13
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			io_cfg    <= hfp_pkg::RST_ZERO;
			tmr_cfg   <= hfp_pkg::RST_TMR;
			mac_cmd   <= hfp_pkg::RST_ZERO;
			mac_wdata <= hfp_pkg::RST_ZERO;
			flow_cfg  <= hfp_pkg::RST_ZERO;
		end else begin
			io_cfg    <= io_q;
			tmr_cfg   <= tmr_q;
			mac_cmd   <= cmd_q;
			mac_wdata <= dat_q;
			flow_cfg  <= flow_q;
		end
	end

	// ------------------------------------------------------------
	// Transmit data push
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			txd_push <= 1'b0;
			txd_data <= 32'h00000000;
		end else begin
			txd_push <= wword && area == HFP_A_TXD; // RL8 RL19
			if (wword && area == HFP_A_TXD) begin
				txd_data <= wfull; // RL8
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux, whole word latched on low half
	// ------------------------------------------------------------
	function automatic logic [31:0] reg_value(input logic [7:0] off);
		if (off == hfp_pkg::RXS_POP || off == hfp_pkg::RXS_NONDESTRUCTIVE_READ_PORT) begin
			reg_value = rxs_head; // RL1 RL2
		end else if (off == hfp_pkg::TXS_POP || off == hfp_pkg::TXS_NONDESTRUCTIVE_READ_PORT) begin
			reg_value = txs_head; // RL6 RL7
		end else if (off == hfp_pkg::OFF_ID) begin
			reg_value = {hfp_pkg::CHIP_ID_VAL, hfp_pkg::CHIP_REV_VAL}; // RL9
		end else if (off == hfp_pkg::OFF_ENDIAN) begin
			reg_value = hfp_pkg::ENDIAN_VAL; // RL10
		end else if (off == hfp_pkg::OFF_RXLVL) begin
			reg_value = rx_levels;
		end else if (off == hfp_pkg::OFF_TXLVL) begin
			reg_value = tx_levels;
		end else if (off == hfp_pkg::OFF_IOCFG) begin
			reg_value = io_q;
		end else if (off == hfp_pkg::OFF_TMRCFG) begin
			reg_value = tmr_q;
		end else if (off == hfp_pkg::OFF_TMRCNT) begin
			reg_value = tmr_count;
		end else if (off == hfp_pkg::OFF_CYCLE) begin
			reg_value = cyc_count;
		end else if (off == hfp_pkg::OFF_DROP) begin
			reg_value = drop_count; // RL14
		end else if (off == hfp_pkg::OFF_MACCMD) begin
			reg_value = cmd_q;
		end else if (off == hfp_pkg::OFF_MACDAT) begin
			reg_value = dat_q;
		end else if (off == hfp_pkg::OFF_FLOW) begin
			reg_value = flow_q;
		end else begin
			reg_value = hfp_pkg::RSV_VAL; // RL11
		end
	endfunction

	logic [31:0] rword;
	logic [31:0] rhold_r;
	always_comb begin
		rword = 32'h00000000;
		if (area == HFP_A_RXD) begin
			rword = rxd_head; // RL4
		end else if (area == HFP_A_RSV) begin
			rword = hfp_pkg::RSV_VAL; // RL11
		end else begin
			rword = reg_value(byte_off);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rhold_r <= 32'h00000000;
		end else if (rd_stb && !hi_half) begin
			rhold_r <= rword; // RL17
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			host_rdata  <= 16'h0000;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= rd_stb;
			if (rd_stb) begin
				host_rdata <= hi_half ? rhold_r[31:16] : rword[15:0]; // RL17
			end
		end
	end

	// ------------------------------------------------------------
	// Pops on completion of the high half read
	// ------------------------------------------------------------
	logic rd_word;
	assign rd_word = rd_stb && hi_half;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rxs_pop  <= 1'b0;
			rxd_pop  <= 1'b0;
			txs_pop  <= 1'b0;
			drop_clr <= 1'b0;
		end else begin
			rxs_pop  <= rd_word && byte_off == hfp_pkg::RXS_POP; // RL1 RL19
			rxd_pop  <= rd_word && area == HFP_A_RXD;            // RL3 RL19
			txs_pop  <= rd_word && byte_off == hfp_pkg::TXS_POP; // RL6 RL19
			drop_clr <= rd_word && byte_off == hfp_pkg::OFF_DROP;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_low_read;
		rd_stb && !hi_half;
	endsequence
	sequence s_high_read;
		rd_stb && hi_half;
	endsequence

	a_rxs_pop_once: assert property (@(posedge sys_clk) disable iff (!rstn) // RL1
		rd_word && byte_off == hfp_pkg::RXS_POP |=> rxs_pop ##1 !rxs_pop)
		else $error("status pop not single");
	a_rxs_nondestructive_read_port_keep: assert property (@(posedge sys_clk) disable iff (!rstn) // RL2
		rd_stb && byte_off == hfp_pkg::RXS_NONDESTRUCTIVE_READ_PORT |=> !rxs_pop)
		else $error("nondestructive_read_port popped status");
	a_rxd_pop_alias: assert property (@(posedge sys_clk) disable iff (!rstn) // RL3
		rd_word && byte_off <= hfp_pkg::RXD_HI |=> rxd_pop)
		else $error("data read did not pop");
	a_rxd_no_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RL5
		wr_stb && byte_off <= hfp_pkg::RXD_HI |=> !rxd_pop && !rxs_pop)
		else $error("write touched receive data");
	a_txd_alias_push: assert property (@(posedge sys_clk) disable iff (!rstn) // RL8
		wword && byte_off <= hfp_pkg::RXD_HI |=> txd_push)
		else $error("data write did not push");
	a_txs_nondestructive_read_port_keep: assert property (@(posedge sys_clk) disable iff (!rstn) // RL7
		rd_stb && byte_off == hfp_pkg::TXS_NONDESTRUCTIVE_READ_PORT |=> !txs_pop)
		else $error("nondestructive_read_port popped tx status");
	a_txd_push_word: assert property (@(posedge sys_clk) disable iff (!rstn) // RL8
		txd_push |-> $past(wr_stb) && $past(hi_half))
		else $error("push without high write");
	a_id_value: assert property (@(posedge sys_clk) disable iff (!rstn) // RL9
		s_low_read ##0 byte_off == hfp_pkg::OFF_ID |=>
		host_rdata == hfp_pkg::CHIP_REV_VAL)
		else $error("bad revision half");
	a_endian_hi: assert property (@(posedge sys_clk) disable iff (!rstn) // RL10
		s_low_read ##0 byte_off == hfp_pkg::OFF_ENDIAN ##1
		s_high_read ##0 byte_off == hfp_pkg::OFF_ENDIAN |=>
		host_rdata == hfp_pkg::ENDIAN_VAL[31:16])
		else $error("bad endian upper half");
	a_low_no_pop: assert property (@(posedge sys_clk) disable iff (!rstn) // RL19
		s_low_read |=> !rxs_pop && !rxd_pop && !txs_pop)
		else $error("pop on low half");
	a_ro_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RL18
		wword && byte_off == hfp_pkg::OFF_ID |=> $stable(tmr_q) && $stable(io_q))
		else $error("read-only write changed state");
	a_tmr_reset: assert property (@(posedge sys_clk) disable iff (!rstn) // RL12
		sw_rst |=> tmr_q == hfp_pkg::RST_TMR)
		else $error("timer config not reset");
	a_flow_reset: assert property (@(posedge sys_clk) disable iff (!rstn) // RL16
		sw_rst |=> flow_q == hfp_pkg::RST_ZERO && io_q == hfp_pkg::RST_ZERO)
		else $error("config not cleared");
endmodule

// >>> hfp_host_model.sv
// Host CPU model driving the 16-bit register bus
// Assumes callers use its tasks one at a time, off the clock edge
`timescale 1ns/1ps
module hfp_host_model (
	// Clock
	input  wire logic              sys_clk,
	// Host bus
	output hfp_pkg::hfp_hreq_s     host,
	input  wire logic [15:0]       host_rdata,
	input  wire logic              host_rvalid
);
	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	initial host = '0;
	// One strobe, held across one rising edge
	task automatic go(input logic [7:0] a, input logic w,
		input logic [15:0] d);
		host.cs    = 1'b1;
		host.rd    = ~w;
		host.wr    = w;
		host.addr  = a[7:1];
		host.wdata = d;
		@(posedge sys_clk);
		#2;
	endtask
	// Released lines show inverse of last value
	task automatic idle();
		host.cs    = 1'b0;
		host.rd    = 1'b0;
		host.wr    = 1'b0;
		host.addr  = ~host.addr;
		host.wdata = ~host.wdata;
	endtask
	// Word read, low half then high half
	task automatic rd32(input logic [7:0] a, output logic [31:0] q);
		@(posedge sys_clk);
		#2;
		go(a, 1'b0, ~host.wdata);
		q[15:0] = host_rvalid ? host_rdata : 16'hxxxx;
		go(a | 8'h02, 1'b0, ~host.wdata);
		q[31:16] = host_rvalid ? host_rdata : 16'hxxxx;
		idle();
	endtask
	// Word write, low half then high half
	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		#2;
		go(a, 1'b1, d[15:0]);
		go(a | 8'h02, 1'b1, d[31:16]);
		idle();
	endtask
endmodule

// >>> host_fifo_ports_and_csr_map_test.sv
// Testbench of the host FIFO ports and register map decoder
// Assumes hfp_pkg, hfp_reg, hfp_top and hfp_host_model are compiled
`timescale 1ns/1ps
module host_fifo_ports_and_csr_map_test;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic               sys_clk = 1'b0;
	logic               rstn = 1'b0;
	logic               sw_rst = 1'b0;
	logic               mac_rvalid = 1'b0;
	hfp_pkg::hfp_hreq_s host;
	logic [15:0]        host_rdata;
	logic               host_rvalid;
	logic               rxs_pop, rxd_pop, txs_pop, txd_push, drop_clr;
	logic [31:0]        txd_data, io_cfg, tmr_cfg, mac_cmd, mac_wdata;
	logic [31:0]        flow_cfg, last_tx;
	logic [31:0]        stat [6];
	logic [31:0]        cfgv [5];
	logic [15:0]        pc [4];
	logic [7:0]         nclr = 8'h00;
	logic [7:0]         rwa [5] = '{8'h88, 8'h8c, 8'ha4, 8'ha8, 8'hac};
	logic [31:0]        rwd [5] = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'h0};
	logic [7:0]         roa [6] = '{8'h50, 8'h64, 8'h40, 8'h44, 8'h48,
		8'h4c};
	int                 num_errors = 0;
	int                 total_checks = 0;
	always #25 sys_clk = ~sys_clk;
	always_comb cfgv = '{io_cfg, tmr_cfg, mac_cmd, mac_wdata, flow_cfg};
	// Far-side FIFO heads follow pop counts
	always @(posedge sys_clk) begin
		if (rstn) begin
			pc[0] <= pc[0] + 16'(rxs_pop);
			pc[1] <= pc[1] + 16'(rxd_pop);
			pc[2] <= pc[2] + 16'(txs_pop);
			pc[3] <= pc[3] + 16'(txd_push);
			nclr  <= nclr + 8'(drop_clr);
			if (txd_push === 1'b1) begin
				last_tx <= txd_data;
			end
		end
	end
	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	hfp_host_model u_host (.sys_clk(sys_clk), .host(host),
		.host_rdata(host_rdata), .host_rvalid(host_rvalid));
	hfp_top dut (.sys_clk(sys_clk), .rstn(rstn), .sw_rst(sw_rst),
		.host(host), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
		.rxs_head({16'h5a00, pc[0]}), .rxs_pop(rxs_pop),
		.rxd_head({16'h5a01, pc[1]}), .rxd_pop(rxd_pop),
		.txs_head({16'h5a02, pc[2]}), .txs_pop(txs_pop),
		.txd_data(txd_data), .txd_push(txd_push),
		.rx_levels(stat[4]), .tx_levels(stat[5]), .tmr_count(stat[0]),
		.cyc_count(stat[1]), .drop_count(stat[2]), .mac_rdata(stat[3]),
		.mac_rvalid(mac_rvalid), .io_cfg(io_cfg), .tmr_cfg(tmr_cfg),
		.mac_cmd(mac_cmd), .mac_wdata(mac_wdata), .flow_cfg(flow_cfg),
		.drop_clr(drop_clr));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, exp, input string m);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		u_host.rd32(a, q);
		chk(q, e, $sformatf("read %h", a));
	endtask
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#2;
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		#2000000;
		num_errors++;
		complete_run();
	end
	initial begin
		logic [31:0] w;
		logic [7:0]  a;
		logic [15:0] n;
		void'($urandom(32'hc46a4708));
		for (int k = 0; k < 4; k++) pc[k] = '0;
		for (int k = 0; k < 6; k++) stat[k] = $urandom;
		repeat (6) @(posedge sys_clk);
		#2 rstn = 1'b1;
		chk(tmr_cfg, hfp_pkg::RST_TMR, "timer cfg");
		for (int k = 0; k < 5; k++) rchk(rwa[k], rwd[k]);
		rchk(8'h50, {hfp_pkg::CHIP_ID_VAL, hfp_pkg::CHIP_REV_VAL});
		rchk(8'h64, 32'h87654321);
		$display("test defaults done");
		// Writes to read-only places
		w = {pc[0], pc[2]};
		for (int k = 0; k < 6; k++) u_host.wr32(roa[k], $urandom);
		settle();
		chk({pc[0], pc[2]}, w, "ro port pops");
		chk(32'(pc[3]), 32'h0, "ro port push");
		rchk(8'h50, {hfp_pkg::CHIP_ID_VAL, hfp_pkg::CHIP_REV_VAL});
		rchk(8'h64, 32'h87654321);
		rchk(8'h60, hfp_pkg::RSV_VAL);
		rchk(8'h94, hfp_pkg::RSV_VAL);
		rchk(8'hb8 + 8'(4 * ($urandom % 18)), hfp_pkg::RSV_VAL);
		$display("test read only done");
		// Status pop and nondestructive_read_port ports
		for (int k = 0; k < 2; k++) begin
			a = k ? 8'h48 : 8'h40;
			n = pc[2 * k];
			rchk(a + 8'h04, {8'h5a, 8'(2 * k), n});
			settle();
			chk(32'(pc[2 * k]), 32'(n), "nondestructive_read_port pops");
			rchk(a, {8'h5a, 8'(2 * k), n});
			settle();
			chk(32'(pc[2 * k]), 32'(n + 16'h1), "pop count");
			rchk(a + 8'h04, {8'h5a, 8'(2 * k), n + 16'h1});
		end
		$display("test status ports done");
		// Receive data at every alias
		for (int i = 0; i < 16; i++) begin
			n = pc[1];
			rchk(8'(4 * i), {16'h5a01, n});
			settle();
			chk(32'(pc[1]), 32'(n + 16'h1), "data pop");
		end
		$display("test receive data done");
		// Transmit data at random aliases
		for (int i = 0; i < 16; i++) begin
			a = 8'(4 * ($urandom % 16));
			w = $urandom;
			n = pc[3];
			u_host.wr32(a, w);
			settle();
			chk(32'(pc[3]), 32'(n + 16'h1), "push count");
			chk(last_tx, w, "push data");
		end
		$display("test transmit data done");
		// Writable registers and software reset
		for (int k = 0; k < 5; k++) begin
			w = $urandom;
			u_host.wr32(rwa[k], w);
			settle();
			chk(cfgv[k], w, "cfg out");
			rchk(rwa[k], w);
		end
		sw_rst = 1'b1;
		@(posedge sys_clk);
		#2 sw_rst = 1'b0;
		settle();
		for (int k = 0; k < 5; k++) chk(cfgv[k], rwd[k], "sw reset");
		$display("test registers done");
		// Status inputs
		rchk(8'h90, stat[0]);
		n = 16'(nclr);
		rchk(8'ha0, stat[2]);
		settle();
		chk(32'(nclr), 32'(n[7:0] + 8'h1), "drop clear");
		mac_rvalid = 1'b1;
		@(posedge sys_clk);
		#2 mac_rvalid = 1'b0;
		settle();
		rchk(8'ha8, stat[3]);
		$display("test status inputs done");
		complete_run();
	end
endmodule
